// >>> sbs_params.svh
// Constants for the serial input select and byte sync block
`ifndef SBS_PARAMS_SVH
`define SBS_PARAMS_SVH

// Word size and bit counter marks
`define SBS_WORD_W 10
`define SBS_CNT_START 4'h1
`define SBS_CNT_HALF 4'h5
`define SBS_CNT_FULL 4'ha
`define SBS_TX_LAST 4'h9

// Comma: first seven received bits, last three ignored
`define SBS_COMMA_LEN 7
`define SBS_COMMA_PAT 7'h7c

// Register offsets and reset values
`define SBS_OFF_STATUS 4'h0
`define SBS_OFF_MASK 4'h4
`define SBS_OFF_STATE 4'h8
`define SBS_MASK_RST 3'h0

// Status bit positions
`define SBS_ST_COMMA 0
`define SBS_ST_LOST 1
`define SBS_ST_SLIP 2

`endif

// >>> sbs_pkg.sv
// Types and shared decoding for the byte sync block
`include "sbs_params.svh"

package sbs_pkg;
  typedef logic [`SBS_WORD_W-1:0] sbs_word_t; // One received or sent word

  // Alignment state
  typedef enum logic [1:0] {
    SBS_FREE = 2'b00, // Alignment disabled
    SBS_HUNT = 2'b01, // Waiting for a comma
    SBS_LOCKED = 2'b10 // Boundary taken from a comma
  } sbs_align_e;

  // Comma decode; bit 0 is the first received
  function automatic logic sbs_is_comma(input sbs_word_t w);
    sbs_is_comma = (w[`SBS_COMMA_LEN-1:0] == `SBS_COMMA_PAT);
  endfunction
endpackage

// >>> sbs_if.sv
// Carriers between the top and its shifter and serializer
`timescale 1ns/1ps

// Receive bit stream into the word window
interface sbs_rx_if;
  logic bit_in; // Selected serial bit
  logic [9:0] window; // Last ten bits, oldest in bit 0
  logic comma_hit; // Window holds a comma
  modport feeder (output bit_in, input window, input comma_hit);
  modport shifter (input bit_in, output window, output comma_hit);
endinterface

// Parallel word into the transmit serializer
interface sbs_tx_if;
  logic [9:0] word; // Word to send
  logic take; // Word latched this cycle
  logic bit_out; // Serial bit, first bit is word bit 0
  modport source (output word, input take, input bit_out);
  modport serializer (input word, output take, output bit_out);
endinterface

// >>> sbs_rx_shifter.sv
// Receive shift window with comma decode
`timescale 1ns/1ps
`include "sbs_params.svh"

module sbs_rx_shifter (
  input wire logic clk,
  input wire logic rst,
  sbs_rx_if.shifter rx
);
  import sbs_pkg::*;

  sbs_word_t window_q; // Newest bit enters at the top

  // Shift right so the oldest bit lands in bit 0
  always_ff @(posedge clk) begin
    if (rst) begin
      window_q <= '0;
    end else begin
      window_q <= {rx.bit_in, window_q[`SBS_WORD_W-1:1]};
    end
  end

  assign rx.window = window_q;
  assign rx.comma_hit = sbs_is_comma(window_q);
endmodule

// >>> sbs_tx_serializer.sv
// Transmit serializer, one bit per clock, bit 0 first
`timescale 1ns/1ps
`include "sbs_params.svh"

module sbs_tx_serializer (
  input wire logic clk,
  input wire logic rst,
  sbs_tx_if.serializer tx
);
  import sbs_pkg::*;

  sbs_word_t shift_q; // Bits still to send
  logic [3:0] cnt_q; // Bit position in the word
  logic take; // Load a new word

  assign take = (cnt_q == `SBS_TX_LAST);

  // Bit counter, wraps every word
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (take) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // Load on wrap, else shift toward bit 0
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_q <= '0;
    end else if (take) begin
      shift_q <= tx.word;
    end else begin
      shift_q <= {1'b0, shift_q[`SBS_WORD_W-1:1]};
    end
  end

  assign tx.take = take;
  assign tx.bit_out = shift_q[0];
endmodule

// >>> sbs_serdes_top.sv
// Input select, loopback, idle outputs and comma byte alignment
`timescale 1ns/1ps
`include "sbs_params.svh"

module sbs_serdes_top (
  input wire logic clk,
  input wire logic rst,
  // Parallel transmit word
  input wire sbs_pkg::sbs_word_t tx_word,
  // Serial inputs
  input wire logic serial_in_primary,
  input wire logic serial_in_secondary,
  input wire logic sig_det_secondary,
  // Control pins
  input wire logic serial_input_select,
  input wire logic loopback_select,
  input wire logic align_enable_in,
  // Open flags: 0 select, 1 loopback, 2 align enable
  input wire logic [2:0] ctl_pin_open,
  // Serial outputs
  output logic serial_out_first,
  output logic serial_out_second,
  // Parallel receive side
  output sbs_pkg::sbs_word_t rx_word,
  output logic rx_byte_clock_odd,
  output logic rx_byte_clock_even,
  output logic comma_detect_flag,
  output logic tx_word_taken,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq
);
  import sbs_pkg::*;

  sbs_rx_if rx_bus (); // Receive window carrier
  sbs_tx_if tx_bus (); // Transmit word carrier

  // Effective control levels
  logic sel_eff; // Secondary input chosen
  logic loop_eff; // Loopback active
  logic align_eff; // Byte sync enabled

  // Receive state
  logic [3:0] cnt_q; // Bits of current word in window
  logic [3:0] cnt_d;
  sbs_word_t rx_word_q; // Presented word
  logic odd_q; // Odd byte clock level
  logic even_q; // Even byte clock level
  logic phase_q; // Which clock owns the next word
  logic flag_q; // Comma flag pulse
  sbs_align_e align_q; // Alignment state
  sbs_align_e align_d;

  // Source tracking
  logic sel_prev_q; // Select level last cycle
  logic loop_prev_q; // Loopback level last cycle
  logic sig_prev_q; // Lost level last cycle
  logic src_change; // Source switched this cycle

  // Serial outputs
  logic out_first_q;
  logic out_second_q;
  logic taken_q;

  // Events
  logic word_full; // Window holds a whole word
  logic comma_take; // Comma accepted for alignment
  logic present; // Word goes out this cycle
  logic comma_soon; // Comma enters the window next cycle
  logic lost; // Secondary chosen with no signal
  logic ev_comma;
  logic ev_lost;
  logic ev_slip;

  // Registers
  logic [2:0] status_q; // Sticky events
  logic [2:0] mask_q; // Interrupt enables
  logic [7:0] rdata_q;
  logic irq_q;

  // Write strobe aimed at one register offset
  function automatic logic wr_hit(input logic wr, input logic [3:0] addr,
    input logic [3:0] off);
    wr_hit = wr && (addr == off);
  endfunction

  // Open pins read high
  assign sel_eff = serial_input_select | ctl_pin_open[0];
  assign loop_eff = loopback_select | ctl_pin_open[1];
  assign align_eff = align_enable_in | ctl_pin_open[2];

  // Transmit serializer
  assign tx_bus.word = tx_word;

  sbs_tx_serializer u_tx (
    .clk (clk),
    .rst (rst),
    .tx (tx_bus.serializer)
  );

  // Receive source mux
  always_comb begin
    if (loop_eff) begin
      rx_bus.bit_in = tx_bus.bit_out;
    end else if (sel_eff) begin
      rx_bus.bit_in = serial_in_secondary;
    end else begin
      rx_bus.bit_in = serial_in_primary;
    end
  end

  // Receive shift window
  sbs_rx_shifter u_rx (
    .clk (clk),
    .rst (rst),
    .rx (rx_bus.shifter)
  );

  // Serial outputs idle high in loopback
  always_ff @(posedge clk) begin
    if (rst) begin
      out_first_q <= 1'b1;
      out_second_q <= 1'b1;
    end else if (loop_eff) begin
      out_first_q <= 1'b1;
      out_second_q <= 1'b1;
    end else begin
      out_first_q <= tx_bus.bit_out;
      out_second_q <= tx_bus.bit_out;
    end
  end

  // Word taken marker for the transmit source
  // One cycle behind the serializer's load
  always_ff @(posedge clk) begin
    if (rst) begin
      taken_q <= 1'b0;
    end else begin
      taken_q <= tx_bus.take;
    end
  end

  // Source change and signal history
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_prev_q <= 1'b0;
      loop_prev_q <= 1'b0;
      sig_prev_q <= 1'b1;
    end else begin
      sel_prev_q <= sel_eff;
      loop_prev_q <= loop_eff;
      sig_prev_q <= lost;
    end
  end

  // Switching source or loopback loses the boundary
  assign src_change = (sel_eff != sel_prev_q) | (loop_eff != loop_prev_q);
  // Secondary chosen, not looped, and no signal seen
  assign lost = sel_eff & ~loop_eff & ~sig_det_secondary;

  // Word boundary decisions
  assign word_full = (cnt_q == `SBS_CNT_FULL);
  // Commas count from the cycle after enable, so the clocks drop first
  assign comma_take = align_eff & (align_q != SBS_FREE) & rx_bus.comma_hit;
  // Bits 7:1 now are bits 6:0 next cycle: a comma is known one cycle early
  assign comma_soon = align_eff & sbs_is_comma({1'b0, rx_bus.window[`SBS_WORD_W-1:1]});
  assign present = word_full | comma_take;

  // Bit counter restarts at each presented word
  always_comb begin
    if (present) begin
      cnt_d = `SBS_CNT_START;
    end else begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= `SBS_CNT_START;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Alignment state machine
  always_comb begin
    align_d = align_q;
    // Free while disabled, hunt until a comma, then locked
    case (align_q)
      SBS_FREE: begin
        if (align_eff) begin
          align_d = SBS_HUNT;
        end
      end
      SBS_HUNT: begin
        if (!align_eff) begin
          align_d = SBS_FREE;
        end else if (comma_take) begin
          align_d = SBS_LOCKED;
        end
      end
      SBS_LOCKED: begin
        if (!align_eff) begin
          align_d = SBS_FREE;
        end else if (src_change) begin
          align_d = SBS_HUNT;
        end
      end
      default: begin
        align_d = SBS_FREE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      align_q <= SBS_FREE;
    end else begin
      align_q <= align_d;
    end
  end

  // Parallel word output
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_word_q <= '1;
    end else if (lost) begin
      rx_word_q <= '1;
    end else if (present) begin
      rx_word_q <= rx_bus.window;
    end
  end

  // Byte clocks: each rises with its own word
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= 1'b1;
      odd_q <= 1'b0;
      even_q <= 1'b0;
    end else if (lost) begin
      // No clocks while the input is lost
      odd_q <= 1'b0;
      even_q <= 1'b0;
    end else if (comma_take) begin
      // Comma word always opens on the odd clock
      odd_q <= 1'b1;
      even_q <= 1'b0;
      phase_q <= 1'b0;
    end else if (comma_soon) begin
      // Drop both clocks so the comma gets a clean rise
      odd_q <= 1'b0;
      even_q <= 1'b0;
    end else if (word_full) begin
      // Plain word on the clock whose turn it is
      odd_q <= phase_q;
      even_q <= ~phase_q;
      phase_q <= ~phase_q;
    end else if (cnt_q == `SBS_CNT_HALF) begin
      // Low half of each word period
      odd_q <= 1'b0;
      even_q <= 1'b0;
    end
  end

  // Comma flag pulse, with the comma word
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= comma_take & ~lost;
    end
  end

  // Events for the status register
  assign ev_comma = comma_take & ~lost;
  assign ev_lost = lost & ~sig_prev_q;
  assign ev_slip = comma_take & ~word_full;

  // Sticky status, set wins over write-one clear
  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      // A one written clears, an event in the same cycle sets
      if (wr_hit(reg_wr, reg_addr, `SBS_OFF_STATUS)) begin
        status_q <= (status_q & ~reg_wdata[2:0]) | {ev_slip, ev_lost, ev_comma};
      end else begin
        status_q <= status_q | {ev_slip, ev_lost, ev_comma};
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_q <= `SBS_MASK_RST;
    end else if (wr_hit(reg_wr, reg_addr, `SBS_OFF_MASK)) begin
      mask_q <= reg_wdata[2:0];
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      // Status and mask use bits 2:0, the rest read zero
      case (reg_addr)
        `SBS_OFF_STATUS: rdata_q <= {5'h00, status_q};
        `SBS_OFF_MASK: rdata_q <= {5'h00, mask_q};
        `SBS_OFF_STATE: rdata_q <= {1'b0, lost, align_q, align_eff, loop_eff, sel_eff, phase_q};
        default: rdata_q <= 8'h00; // Unmapped reads zero
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  // Outputs straight from flops
  assign serial_out_first = out_first_q;
  assign serial_out_second = out_second_q;
  assign rx_word = rx_word_q;
  assign rx_byte_clock_odd = odd_q;
  assign rx_byte_clock_even = even_q;
  assign comma_detect_flag = flag_q;
  assign tx_word_taken = taken_q;
  assign reg_rdata = rdata_q;
  assign irq = irq_q;
endmodule

// >>> sbs_serdes_checker.sv
// Concurrent checks on the byte sync top ports
`timescale 1ns/1ps

module sbs_serdes_checker (
  input wire logic clk,
  input wire logic rst,
  input wire sbs_pkg::sbs_word_t tx_word,
  input wire logic serial_in_primary,
  input wire logic serial_in_secondary,
  input wire logic sig_det_secondary,
  input wire logic serial_input_select,
  input wire logic loopback_select,
  input wire logic align_enable_in,
  input wire logic [2:0] ctl_pin_open,
  input wire logic serial_out_first,
  input wire logic serial_out_second,
  input wire sbs_pkg::sbs_word_t rx_word,
  input wire logic rx_byte_clock_odd,
  input wire logic rx_byte_clock_even,
  input wire logic comma_detect_flag,
  input wire logic tx_word_taken,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq
);
  import sbs_pkg::*;
  logic loop_eff; // Loopback pin or open pin
  logic sel_eff; // Select pin or open pin
  logic align_eff; // Align pin or open pin
  logic lost; // Secondary chosen with no signal
  assign loop_eff = loopback_select | ctl_pin_open[1];
  assign sel_eff = serial_input_select | ctl_pin_open[0];
  assign align_eff = align_enable_in | ctl_pin_open[2];
  assign lost = sel_eff & ~loop_eff & ~sig_det_secondary;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Loopback held long enough to pass the output stages
  sequence s_loop_held;
    loop_eff ##1 loop_eff ##1 loop_eff;
  endsequence
  // Lost input held long enough to pass the word register
  sequence s_lost_held;
    lost ##1 lost ##1 lost;
  endsequence

  AST_FLAG_ALIGN: assert property (comma_detect_flag |-> $past(align_eff))
    else $error("comma flag without alignment enabled");
  AST_FLAG_WORD: assert property (comma_detect_flag |-> rx_word[6:0] == 7'h7c)
    else $error("comma flag beside a non-comma word");
  AST_FLAG_PULSE: assert property (comma_detect_flag |=> !comma_detect_flag)
    else $error("comma flag longer than one cycle");
  AST_ODD_COMMA: assert property (comma_detect_flag |-> $rose(rx_byte_clock_odd) && !rx_byte_clock_even)
    else $error("comma word not on odd byte clock rise");
  AST_OUTS_PAIR: assert property (serial_out_first == serial_out_second)
    else $error("serial outputs differ");
  AST_LOOP_IDLE: assert property (s_loop_held |-> serial_out_first && serial_out_second)
    else $error("serial outputs not idle high in loopback");
  AST_LOST_ONES: assert property (s_lost_held |-> rx_word == 10'h3ff && !rx_byte_clock_odd)
    else $error("lost secondary input not all ones");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read answer cycle");
endmodule

bind sbs_serdes_top sbs_serdes_checker u_chk (.*);

// >>> sbs_remote_model.sv
// Remote transceiver model repeating one word on a serial line
`timescale 1ns/1ps

module sbs_remote_model (
  input wire logic clk,
  input wire sbs_pkg::sbs_word_t word,
  input wire logic present,
  output logic serial_bit,
  output logic sig_det
);
  import sbs_pkg::*;
  logic [3:0] pos_q = 4'h0; // Bit position in the word
  logic fill_q = 1'b0; // Changing filler while no signal

  // Step one bit per clock, wrap after ten
  always_ff @(posedge clk) begin
    pos_q <= (pos_q == 4'h9) ? 4'h0 : pos_q + 4'h1;
    fill_q <= ~fill_q;
  end
  assign serial_bit = present ? word[pos_q] : fill_q;
  assign sig_det = present;
endmodule

// >>> tb.sv
// Self-checking bench for the byte sync top
`timescale 1ns/1ps

module tb;
  import sbs_pkg::*;
  logic clk = 1'b0; // 200 MHz clock
  logic rst = 1'b1; // Synchronous reset
  sbs_word_t tx_word, rx_word, word_a, word_b; // Sent and received words
  logic serial_in_primary, serial_in_secondary, sig_det_secondary, present_b;
  logic serial_input_select, loopback_select, align_enable_in, reg_wr, reg_rd;
  logic [2:0] ctl_pin_open;
  logic serial_out_first, serial_out_second, rx_byte_clock_odd, rx_byte_clock_even;
  logic comma_detect_flag, tx_word_taken, irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  always #2.5 clk = ~clk;

  sbs_serdes_top u_dut (.*);
  sbs_remote_model u_far_a (.clk(clk), .word(word_a), .present(1'b1),
    .serial_bit(serial_in_primary), .sig_det());
  sbs_remote_model u_far_b (.clk(clk), .word(word_b), .present(present_b),
    .serial_bit(serial_in_secondary), .sig_det(sig_det_secondary));

  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic set_ctl(input logic s, l, a, input logic [2:0] o);
    @(posedge clk);
    serial_input_select <= s;
    loopback_select <= l;
    align_enable_in <= a;
    ctl_pin_open <= o;
  endtask

  task automatic wait_flag(output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 60 && !seen; i++) begin
      @(posedge clk);
      #1 seen = (comma_detect_flag === 1'b1);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Switch source, let it realign, compare the comma word
  task automatic t_route(input logic s, l, input sbs_word_t exp);
    logic seen;
    set_ctl(s, l, 1'b1, 3'b000);
    repeat (12) @(posedge clk);
    wait_flag(seen);
    wait_flag(seen);
    check(seen === 1'b1 && rx_word === exp, "routed comma word");
    if (l) begin
      check(serial_out_first === 1'b1 && serial_out_second === 1'b1, "idle outs");
    end
  endtask

  // Transmit word must show bit 0 first on the serial output
  task automatic t_tx_out;
    logic [19:0] bits;
    logic hit;
    int n;
    hit = 1'b0;
    n = 0;
    set_ctl(1'b0, 1'b0, 1'b1, 3'b000);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      #1 bits[i] = serial_out_first;
      n += (tx_word_taken === 1'b1);
    end
    for (int k = 0; k < 10; k++) begin
      hit = hit | (bits[k +: 10] === tx_word);
    end
    check(hit, "serial output stream");
    check(n == 2, "one word taken per ten cycles");
  endtask

  // No flag while alignment is off, commas still flowing
  task automatic t_no_align;
    int n, n_odd, n_even;
    n = 0;
    n_odd = 0;
    n_even = 0;
    set_ctl(1'b0, 1'b1, 1'b0, 3'b000);
    repeat (40) begin
      @(posedge clk);
      #1 n += (comma_detect_flag !== 1'b0);
      n_odd += (rx_byte_clock_odd === 1'b1);
      n_even += (rx_byte_clock_even === 1'b1);
    end
    check(n == 0, "flag while alignment off");
    check(n_odd == 10 && n_even == 10, "byte clocks alternate");
  endtask

  // Open loopback and align pins read high
  task automatic t_open;
    logic seen;
    logic [7:0] d;
    set_ctl(1'b0, 1'b0, 1'b0, 3'b110);
    wait_flag(seen);
    check(seen === 1'b1 && serial_out_first === 1'b1, "open pins high");
    reg_read(4'h8, d);
    check(d[7:6] === 2'b00 && d[3:1] === 3'b110, "open pins state");
    set_ctl(1'b0, 1'b0, 1'b1, 3'b001);
    repeat (12) @(posedge clk);
    wait_flag(seen);
    check(seen === 1'b1 && rx_word === 10'h37c, "open select pin");
  endtask

  // Secondary selected with no signal gives all ones
  task automatic t_lost;
    logic ok;
    logic [7:0] d;
    ok = 1'b1;
    set_ctl(1'b1, 1'b0, 1'b1, 3'b000);
    present_b <= 1'b0;
    repeat (4) @(posedge clk);
    repeat (10) begin
      @(posedge clk);
      #1 ok = ok & (rx_word === 10'h3ff) & (rx_byte_clock_odd === 1'b0);
      ok = ok & (rx_byte_clock_even === 1'b0);
    end
    check(ok, "lost input word");
    reg_read(4'h0, d);
    check(d[1] === 1'b1, "lost status");
    present_b <= 1'b1;
  endtask

  // Status, mask and interrupt line
  task automatic t_regs;
    logic [7:0] d;
    set_ctl(1'b0, 1'b1, 1'b1, 3'b000);
    repeat (30) @(posedge clk);
    #1 check(irq === 1'b0, "irq masked");
    reg_write(4'h4, 8'h01);
    repeat (2) @(posedge clk);
    #1 check(irq === 1'b1, "irq on comma");
    reg_read(4'h0, d);
    check(d[0] === 1'b1, "comma status");
    set_ctl(1'b0, 1'b1, 1'b0, 3'b000);
    reg_write(4'h0, 8'h07);
    repeat (2) @(posedge clk);
    #1 check(irq === 1'b0, "irq after clear");
    reg_read(4'h0, d);
    check(d === 8'h00, "status cleared");
    reg_read(4'h4, d);
    check(d === 8'h01, "mask readback");
    reg_read(4'hc, d);
    check(d === 8'h00, "unmapped read");
  endtask

  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      $display("MISMATCH %0t timeout", $time);
      summarize();
    end
  end

  initial begin
    tx_word = 10'h27c;
    word_a = 10'h07c;
    word_b = 10'h37c;
    present_b = 1'b1;
    serial_input_select = 1'b0;
    loopback_select = 1'b0;
    align_enable_in = 1'b1;
    ctl_pin_open = 3'b000;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (2) @(posedge clk);
    #1 check(serial_out_first === 1'b1 && rx_word === 10'h3ff && irq === 1'b0, "reset");
    @(posedge clk);
    rst <= 1'b0;
    t_route(1'b0, 1'b0, 10'h07c);
    t_route(1'b1, 1'b0, 10'h37c);
    t_route(1'b0, 1'b1, 10'h27c);
    t_route(1'b1, 1'b1, 10'h27c);
    t_tx_out();
    t_no_align();
    t_open();
    t_lost();
    t_regs();
    summarize();
  end
endmodule
